// File: core/ifl_pkg.sv
package ifl_pkg;

    // register pointer map
    localparam logic [6:0] REG_BREAKER_LOG = 7'h31;
    localparam logic [6:0] REG_UV_STATUS = 7'h35;
    localparam logic [6:0] REG_OV_STATUS = 7'h36;
    localparam logic [6:0] REG_OCW_STATUS = 7'h37;
    localparam logic [6:0] REG_LED_CTRL = 7'h43;
    localparam logic [6:0] REG_LED_PHPU = 7'h44;
    localparam logic [6:0] REG_LED_LEVEL = 7'h45;
    // highest valid pointer, buffer window included
    localparam logic [6:0] REG_PTR_MAX = 7'h49;

    localparam logic [7:0] LED_CTRL_RESET = 8'h0f;
    localparam logic [7:0] LED_PHPU_RESET = 8'h00;

    // field positions
    localparam int LOG_SLOW_LSB = 4;
    localparam int LOG_FAST_LSB = 0;
    localparam int LED_OFF_LSB = 0;
    localparam int LED_BLINK_LSB = 4;
    localparam int LED_PULLUP_LSB = 0;
    localparam int LED_INV_LSB = 4;
    localparam int MISC_ALERT_BIT = 4;

    // slave address prefix above the two select pairs
    localparam logic [2:0] SLAVE_ADDR_PREFIX = 3'h3;
    // select pin codes: low, high, open
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] PAIR_LOW = 2'h2;
    localparam logic [1:0] PAIR_HIGH = 2'h1;
    localparam logic [1:0] PAIR_OPEN = 2'h0;

    // blink timebase: 1 Hz, half period
    localparam longint CLK_PERIOD_NS = 20;
    localparam longint BLINK_HALF_NS = 500000000;
    localparam int BLINK_HALF_CYC = int'(BLINK_HALF_NS / CLK_PERIOD_NS);

    localparam int NUM_LED = 4;
    localparam int NUM_CH = 2;

    typedef struct packed {
        logic [1:0] slow;
        logic [1:0] fast;
    } ifl_trip_t;

    typedef struct packed {
        logic [7:0] uv;
        logic [7:0] ov;
        logic [7:0] ocw;
    } ifl_warn_t;

endpackage

// File: core/ifl_top.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - breaker log: slow bits 5:4, fast 1:0
// R2 - fault level is NOR of channel flags
// R3 - trip flags latch until channel restart
// R4 - overcurrent shutdown pulls fault output low
// R5 - uv/ov shutdown never asserts fault output
// R6 - disabled channel releases its fault output
// R7 - alert low on any condition, mirrored
// R8 - alert is NOR of four status registers
// R9 - off bit set turns driver off
// R10 - blink bit toggles driver at 1 Hz
// R11 - phase bits invert blink per driver
// R12 - weak pullup bit disables the driver
// R13 - pin level register reads pin levels
// R14 - slave address from two tri-level selects
// R15 - slave only, never drives serial clock
// R16 - master clocks at most 400 kHz
// R17 - eight bits then acknowledge slot
// R18 - sda edge while scl high is framing
// R19 - start on sda fall, stop on rise
// R20 - stop accepted except in start's high
// R21 - writes chain; reads need repeated start
// R22 - acknowledge received bytes on ninth clock
// R23 - out of range pointer gets a nack
// R24 - pointer increments and wraps to zero
// R25 - writes to read-only bits are ignored
// R26 - one shared divided 1 Hz timebase
module ifl_top #(
    parameter int BLINK_HALF = ifl_pkg::BLINK_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    input wire logic [1:0] addr_select_high,
    input wire logic [1:0] addr_select_low,
    input wire ifl_pkg::ifl_trip_t trip_event,
    input wire logic [1:0] on_pin,
    input wire logic [1:0] chan_enable,
    input wire ifl_pkg::ifl_warn_t warn_status,
    output logic [1:0] fault_out,
    output logic [1:0] fault_oe_b,
    output logic alert_out,
    output logic alert_oe_b,
    output logic misc_alert_bit,
    input wire logic [3:0] led_pin_in,
    output logic [3:0] led_out,
    output logic [3:0] led_oe_b,
    output logic [3:0] led_pullup_en
);
    import ifl_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
        ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK
    } ifl_state_t;

    function automatic logic [1:0] pair_code(input logic [1:0] sel);
        if (sel == SEL_LOW)
            pair_code = PAIR_LOW;
        else if (sel == SEL_HIGH)
            pair_code = PAIR_HIGH;
        else
            pair_code = PAIR_OPEN;
    endfunction

    function automatic logic [6:0] next_ptr(input logic [6:0] p);
        if (p >= REG_PTR_MAX)
            next_ptr = 7'h00;
        else
            next_ptr = p + 7'h01;
    endfunction

    // synchronisers: first stage feeds only the second
    logic [1:0] scl_sy, sda_sy;
    logic [3:0] led_sy1, led_sy2;
    logic [1:0] sel_hi_sy1, sel_hi_sy2, sel_lo_sy1, sel_lo_sy2;
    logic scl_d, sda_d;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            led_sy1 <= 4'hf;
            led_sy2 <= 4'hf;
            sel_hi_sy1 <= 2'h0;
            sel_hi_sy2 <= 2'h0;
            sel_lo_sy1 <= 2'h0;
            sel_lo_sy2 <= 2'h0;
        end else begin
            scl_sy <= {scl_sy[0], scl_in};
            sda_sy <= {sda_sy[0], sda_in};
            scl_d <= scl_sy[1];
            sda_d <= sda_sy[1];
            led_sy1 <= led_pin_in;
            led_sy2 <= led_sy1;
            sel_hi_sy1 <= addr_select_high;
            sel_hi_sy2 <= sel_hi_sy1;
            sel_lo_sy1 <= addr_select_low;
            sel_lo_sy2 <= sel_lo_sy1;
        end
    end

    wire scl_s = scl_sy[1];
    wire sda_s = sda_sy[1];
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    // R18 framing edges
    // R19 start and stop
    wire start_seen = scl_s && scl_d && sda_d && !sda_s;
    wire stop_raw = scl_s && scl_d && !sda_d && sda_s;

    // address straps loaded on each of the first three cycles after reset release, then held
    logic [6:0] slave_addr;
    logic [1:0] strap_wait;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_wait <= 2'h0;
            slave_addr <= 7'h00;
        end else if (strap_wait != 2'h3) begin
            strap_wait <= strap_wait + 2'h1;
            // R14 tri-level address
            slave_addr <= {SLAVE_ADDR_PREFIX, pair_code(sel_hi_sy2),
                           pair_code(sel_lo_sy2)};
        end
    end

    // trip flags
    logic [1:0] slow_flag, fast_flag;
    wire [1:0] chan_active = on_pin & chan_enable;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            slow_flag <= 2'h0;
            fast_flag <= 2'h0;
        end else begin
            // R3 latch until restart; a trip in the same cycle wins
            slow_flag <= trip_event.slow | (slow_flag & chan_active);
            fast_flag <= trip_event.fast | (fast_flag & chan_active);
        end
    end

    // R1 breaker log layout
    wire [7:0] breaker_trip_log = (8'(slow_flag) << LOG_SLOW_LSB)
        | (8'(fast_flag) << LOG_FAST_LSB);

    logic [1:0] fault_low;
    logic alert_low;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_low <= 2'h0;
            alert_low <= 1'b0;
        end else begin
            // R2 R4 R5 R6 only overcurrent trips drive the pin
            fault_low <= slow_flag | fast_flag;
            // R7 R8 alert from all four status sources
            alert_low <= |{breaker_trip_log, warn_status.uv,
                           warn_status.ov, warn_status.ocw};
        end
    end

    assign fault_out = 2'h0;
    assign fault_oe_b = ~fault_low;
    assign alert_out = 1'b0;
    assign alert_oe_b = ~alert_low;
    // R7 mirror for the misc status register
    assign misc_alert_bit = alert_low;

    // R26 shared blink timebase
    logic [31:0] blink_cnt;
    logic blink_phase;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            blink_cnt <= 32'h0;
            blink_phase <= 1'b0;
        end else if (blink_cnt >= 32'(BLINK_HALF - 1)) begin
            blink_cnt <= 32'h0;
            blink_phase <= !blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // LED registers, written over the serial port
    logic [7:0] led_blink_and_off_control;
    logic [7:0] led_blink_inversion_and_pullup;

    wire [3:0] led_off_bit = led_blink_and_off_control[LED_OFF_LSB +: 4];
    wire [3:0] led_blink_bit = led_blink_and_off_control[LED_BLINK_LSB +: 4];
    wire [3:0] led_blink_inversion = led_blink_inversion_and_pullup[LED_INV_LSB +: 4];
    wire [3:0] led_weak_pullup_bit =
        led_blink_inversion_and_pullup[LED_PULLUP_LSB +: 4];

    // R10 R11 blink in phase or inverted
    wire [3:0] blink_on = {4{blink_phase}} ^ led_blink_inversion;
    // R9 off bit, overridden by blink
    wire [3:0] led_sink = (led_blink_bit & blink_on)
        | (~led_blink_bit & ~led_off_bit);
    logic [3:0] led_drive;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            led_drive <= 4'h0;
        else
            // R12 pullup disables the driver
            led_drive <= led_sink & ~led_weak_pullup_bit;
    end
    assign led_out = 4'h0;
    assign led_oe_b = ~led_drive;
    assign led_pullup_en = led_weak_pullup_bit;

    // R13 pin levels, read only
    wire [7:0] led_pin_level = {4'h0, led_sy2};

    // serial slave
    ifl_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txsh;
    logic [6:0] ptr;
    logic rw;
    logic hold_low;
    logic ack_ok;
    logic start_high;

    // R20 no stop in the same high as a start
    wire stop_seen = stop_raw && !start_high;

    logic [7:0] rd_data;
    always_comb begin
        case (ptr)
            REG_BREAKER_LOG: rd_data = breaker_trip_log;
            REG_UV_STATUS: rd_data = warn_status.uv;
            REG_OV_STATUS: rd_data = warn_status.ov;
            REG_OCW_STATUS: rd_data = warn_status.ocw;
            REG_LED_CTRL: rd_data = led_blink_and_off_control;
            REG_LED_PHPU: rd_data = led_blink_inversion_and_pullup;
            REG_LED_LEVEL: rd_data = led_pin_level;
            default: rd_data = 8'h00;
        endcase
    end

    wire byte_done = scl_fall && (bitcnt == 4'h8);
    wire wr_take = (state == ST_WDATA) && byte_done;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            led_blink_and_off_control <= LED_CTRL_RESET;
            led_blink_inversion_and_pullup <= LED_PHPU_RESET;
        end else if (wr_take) begin
            // R25 only the two writable registers take data
            if (ptr == REG_LED_CTRL)
                led_blink_and_off_control <= shreg;
            else if (ptr == REG_LED_PHPU)
                led_blink_inversion_and_pullup <= shreg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            start_high <= 1'b0;
        else if (start_seen)
            start_high <= 1'b1;
        else if (scl_fall)
            start_high <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            txsh <= 8'h00;
            ptr <= 7'h00;
            rw <= 1'b0;
            hold_low <= 1'b0;
            ack_ok <= 1'b0;
        end else if (start_seen) begin
            // R21 repeated start restarts address phase, pointer kept
            state <= ST_ADDR;
            bitcnt <= 4'h0;
            hold_low <= 1'b0;
        end else if (stop_seen) begin
            state <= ST_IDLE;
            hold_low <= 1'b0;
        end else if (scl_rise) begin
            // R17 eight data bits per byte
            case (state)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    shreg <= {shreg[6:0], sda_s};
                    bitcnt <= bitcnt + 4'h1;
                end
                ST_RDATA: bitcnt <= bitcnt + 4'h1;
                ST_RACK: ack_ok <= !sda_s;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: if (bitcnt == 4'h8) begin
                    if (shreg[7:1] == slave_addr) begin
                        // R22 acknowledge address
                        hold_low <= 1'b1;
                        rw <= shreg[0];
                        state <= ST_ACK_ADDR;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_CMD: if (bitcnt == 4'h8) begin
                    // R23 nack a pointer beyond the map
                    if (shreg <= {1'b0, REG_PTR_MAX}) begin
                        hold_low <= 1'b1;
                        ptr <= shreg[6:0];
                        state <= ST_ACK_CMD;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_WDATA: if (bitcnt == 4'h8) begin
                    hold_low <= 1'b1;
                    // R24 advance after each byte written
                    ptr <= next_ptr(ptr);
                    state <= ST_ACK_W;
                end
                ST_ACK_ADDR: begin
                    bitcnt <= 4'h0;
                    if (rw) begin
                        txsh <= rd_data;
                        hold_low <= !rd_data[7];
                        state <= ST_RDATA;
                    end else begin
                        hold_low <= 1'b0;
                        state <= ST_CMD;
                    end
                end
                ST_ACK_CMD, ST_ACK_W: begin
                    // R21 further bytes are data, back to back
                    hold_low <= 1'b0;
                    bitcnt <= 4'h0;
                    state <= ST_WDATA;
                end
                ST_RDATA: begin
                    if (bitcnt == 4'h8) begin
                        hold_low <= 1'b0;
                        // R24 advance after each byte read
                        ptr <= next_ptr(ptr);
                        state <= ST_RACK;
                    end else begin
                        txsh <= {txsh[6:0], 1'b0};
                        hold_low <= !txsh[6];
                    end
                end
                ST_RACK: begin
                    bitcnt <= 4'h0;
                    if (ack_ok) begin
                        txsh <= rd_data;
                        hold_low <= !rd_data[7];
                        state <= ST_RDATA;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // R15 only sda is ever pulled; scl is input only
    assign sda_out = 1'b0;
    assign sda_oe_b = !hold_low;

endmodule

// File: dv/ifl_top_chk.sv
`timescale 1ns/1ps
module ifl_top_chk #(
    parameter int BLINK_HALF = ifl_pkg::BLINK_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_b,
    input wire logic [1:0] addr_select_high,
    input wire logic [1:0] addr_select_low,
    input wire ifl_pkg::ifl_trip_t trip_event,
    input wire logic [1:0] on_pin,
    input wire logic [1:0] chan_enable,
    input wire ifl_pkg::ifl_warn_t warn_status,
    input wire logic [1:0] fault_out,
    input wire logic [1:0] fault_oe_b,
    input wire logic alert_out,
    input wire logic alert_oe_b,
    input wire logic misc_alert_bit,
    input wire logic [3:0] led_pin_in,
    input wire logic [3:0] led_out,
    input wire logic [3:0] led_oe_b,
    input wire logic [3:0] led_pullup_en
);
    import ifl_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    property p_od;
        sda_out == 1'b0 && alert_out == 1'b0 && fault_out == 2'h0
            && led_out == 4'h0;
    endproperty
    a_od: assert property (p_od)
        else $error("open-drain pin driven high");
    // device data moves one cycle after the synced scl fall
    property p_sda_scl;
        $changed(sda_oe_b) |-> !scl_in && !$past(scl_in, 2);
    endproperty
    a_sda_scl: assert property (p_sda_scl)
        else $error("sda changed near scl high");
    property p_trip;
        trip_event.slow[0] || trip_event.fast[0] |-> ##2 !fault_oe_b[0];
    endproperty
    a_trip: assert property (p_trip)
        else $error("trip did not assert fault");
    property p_latch;
        !fault_oe_b[0] && $past(on_pin[0]) && $past(chan_enable[0])
            |=> !fault_oe_b[0];
    endproperty
    a_latch: assert property (p_latch)
        else $error("fault dropped on live channel");
    property p_rel;
        !(on_pin[1] && chan_enable[1]) && trip_event.slow[1] == 1'b0
            && trip_event.fast[1] == 1'b0 |-> ##2 fault_oe_b[1];
    endproperty
    a_rel: assert property (p_rel)
        else $error("fault held on disabled channel");
    property p_alert;
        warn_status != '0 |=> !alert_oe_b;
    endproperty
    a_alert: assert property (p_alert)
        else $error("alert missed for warning");
    property p_mirror;
        misc_alert_bit == !alert_oe_b;
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("status bit differs from alert");
    property p_pullup;
        led_pullup_en != 4'h0
            |=> (led_oe_b & $past(led_pullup_en)) == $past(led_pullup_en);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("driver sinks with pullup on");
endmodule

bind ifl_top ifl_top_chk #(.BLINK_HALF(BLINK_HALF)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b),
    .addr_select_high(addr_select_high), .addr_select_low(addr_select_low),
    .trip_event(trip_event), .on_pin(on_pin), .chan_enable(chan_enable),
    .warn_status(warn_status), .fault_out(fault_out),
    .fault_oe_b(fault_oe_b), .alert_out(alert_out), .alert_oe_b(alert_oe_b),
    .misc_alert_bit(misc_alert_bit), .led_pin_in(led_pin_in),
    .led_out(led_out), .led_oe_b(led_oe_b), .led_pullup_en(led_pullup_en));

// File: dv/ifl_i2c_master.sv
`timescale 1ns/1ps
module ifl_i2c_master (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // bench scl runs far above the bus limit to keep runs short
    // each phase spans only 2 system clocks, shorter than the 3-cycle sync lag
    localparam time QTR = 40ns;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start();
        #QTR sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b0;
    endtask
    // sda rises in the start's own high pulse: not a stop
    task automatic start_stop();
        #QTR sda_drv = 1'b0;
        #QTR sda_drv = 1'b1;
        #QTR scl = 1'b0;
    endtask
    task automatic xbit(input logic b, output logic r);
        #QTR sda_drv = b;
        #QTR scl = 1'b1;
        #QTR r = sda;
        #QTR scl = 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ak,
                         output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r[i]);
        end
        xbit(ak, a);
    endtask
    // only called after a clocked byte
    task automatic stop();
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b1;
        #QTR;
    endtask
endmodule

// File: dv/tb_ifl_top.sv
`timescale 1ns/1ps
module tb_ifl_top;
    import ifl_pkg::*;
    localparam int BH = 8;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] phpu;
        logic [3:0] pins;
        logic [3:0] oe;
    } ifl_row_t;
    // steady rows only; blinking is timed by hand below
    localparam ifl_row_t ROWS [5] = '{24'h0f005f, 24'h0000a0, 24'h050035,
        24'h0003c3, 24'h0a0c6e};
    logic ref_clk, rst_b = 1'b0, scl_in, sda_drv, sda_in, a, lvl;
    logic [1:0] addr_select_high = 2'h0, addr_select_low = 2'h0;
    logic [1:0] on_pin = 2'h3, chan_enable = 2'h3, fault_out, fault_oe_b;
    ifl_trip_t trip_event = '0;
    ifl_warn_t warn_status = '0;
    logic [3:0] led_pin_in = 4'h0, led_out, led_oe_b, led_pullup_en;
    logic sda_out, sda_oe_b, alert_out, alert_oe_b, misc_alert_bit;
    logic [7:0] rbuf [64];
    logic [7:0] wq [$];
    logic [6:0] dev;
    int fail_count = 0, n_checks = 0, n;
    assign sda_in = sda_drv & (sda_oe_b | sda_out);
    ifl_top #(.BLINK_HALF(BH)) uut (
        .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_b(sda_oe_b),
        .addr_select_high(addr_select_high),
        .addr_select_low(addr_select_low), .trip_event(trip_event),
        .on_pin(on_pin), .chan_enable(chan_enable),
        .warn_status(warn_status), .fault_out(fault_out),
        .fault_oe_b(fault_oe_b), .alert_out(alert_out),
        .alert_oe_b(alert_oe_b), .misc_alert_bit(misc_alert_bit),
        .led_pin_in(led_pin_in), .led_out(led_out), .led_oe_b(led_oe_b),
        .led_pullup_en(led_pullup_en));
    ifl_i2c_master m (.scl(scl_in), .sda_drv(sda_drv), .sda(sda_in));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic go_reset(input int h, input int l);
        rst_b = 1'b0;
        addr_select_high = 2'(h);
        addr_select_low = 2'(l);
        tick(8);
        rst_b = 1'b1;
        tick(12);
    endtask
    task automatic adr(input logic rw);
        m.start();
        m.xbyte({dev, rw}, 1'b1, rbuf[63], a);
    endtask
    task automatic wr(input logic [7:0] p);
        adr(1'b0);
        m.xbyte(p, 1'b1, rbuf[63], a);
        chk("cmd ack", 32'h0, a);
        foreach (wq[i]) begin
            m.xbyte(wq[i], 1'b1, rbuf[63], a);
            chk("data ack", 32'h0, a);
        end
        m.stop();
        tick(4);
    endtask
    // preset pointer, then repeated start and a burst read
    task automatic rd(input logic [7:0] p, input int c);
        adr(1'b0);
        m.xbyte(p, 1'b1, rbuf[63], a);
        chk("cmd ack", 32'h0, a);
        adr(1'b1);
        for (int i = 0; i < c; i++) begin
            m.xbyte(8'hff, 1'(i == c - 1), rbuf[i], a);
        end
        m.stop();
        tick(4);
    endtask
    function automatic logic [1:0] pair(input logic [1:0] c);
        return c == 2'h0 ? 2'h2 : c == 2'h1 ? 2'h1 : 2'h0;
    endfunction
    initial begin
        for (int i = 8; i >= 0; i--) begin
            go_reset(i / 3, i % 3);
            dev = {3'h3, pair(addr_select_high), pair(addr_select_low)};
            adr(1'b0);
            m.stop();
            chk("own address ack", 32'h0, a);
            dev = dev ^ 7'h01;
            adr(1'b0);
            m.stop();
            chk("other address ack", 32'h1, a);
            dev = dev ^ 7'h01;
        end
        chk("led_oe_b reset", 32'hf, led_oe_b);
        rd(8'h43, 2);
        chk("ctrl reset", 32'h0f, rbuf[0]);
        chk("phpu reset", 32'h00, rbuf[1]);
        for (int k = 0; k < 5; k++) begin
            led_pin_in = ROWS[k].pins;
            wq = '{ROWS[k].ctrl, ROWS[k].phpu, 8'hff};
            wr(8'h43);
            chk("led_oe_b", 32'(ROWS[k].oe), led_oe_b);
            chk("pullup", 32'(ROWS[k].phpu[3:0]), led_pullup_en);
            rd(8'h42, 4);
            chk("ctrl", 32'(ROWS[k].ctrl), rbuf[1]);
            chk("phpu", 32'(ROWS[k].phpu), rbuf[2]);
            chk("pin level", 32'(ROWS[k].pins), rbuf[3]);
        end
        wq = '{};
        wr(8'h44);
        adr(1'b0);
        m.xbyte(8'h4a, 1'b1, rbuf[63], a);
        m.stop();
        chk("bad cmd ack", 32'h1, a);
        adr(1'b1);
        m.xbyte(8'hff, 1'b1, rbuf[0], a);
        m.stop();
        chk("pointer kept", 32'h0c, rbuf[0]);
        tick(4);
        m.start_stop();
        m.xbyte({dev, 1'b0}, 1'b1, rbuf[63], a);
        m.stop();
        chk("stop beside start", 32'h0, a);
        tick(4);
        trip_event.slow[1] = 1'b1;
        tick(1);
        trip_event = '0;
        tick(3);
        chk("fault_oe_b", 32'h1, fault_oe_b);
        chk("misc_alert_bit", 32'h1, misc_alert_bit);
        trip_event.fast[0] = 1'b1;
        tick(1);
        trip_event = '0;
        rd(8'h49, 51);
        chk("latched fault", 32'h0, fault_oe_b);
        chk("breaker log", 32'h21, rbuf[50]);
        chan_enable[1] = 1'b0;
        on_pin[0] = 1'b0;
        tick(4);
        chk("fault released", 32'h3, fault_oe_b);
        chk("alert idle", 32'h1, alert_oe_b);
        chan_enable = 2'h3;
        on_pin = 2'h3;
        rd(8'h31, 1);
        chk("log cleared", 32'h0, rbuf[0]);
        for (int j = 0; j < 3; j++) begin
            warn_status = 24'h10 << (8 * j);
            tick(3);
            chk("alert on warning", 32'h0, alert_oe_b);
            chk("fault on warning", 32'h3, fault_oe_b);
            warn_status = '0;
            tick(3);
        end
        wq = '{8'h31, 8'h20};
        wr(8'h43);
        chk("steady leds", 32'h0, led_oe_b[3:2]);
        for (int t = 0; t < 3 * BH; t++) begin
            chk("blink phase", 32'(!led_oe_b[0]), led_oe_b[1]);
            tick(1);
        end
        for (int e = 0; e < 2; e++) begin
            lvl = led_oe_b[0];
            n = 0;
            while (led_oe_b[0] === lvl && n < 4 * BH) begin
                tick(1);
                n++;
            end
        end
        chk("blink half period", BH, n);
        test_done();
    end
    initial begin
        #1500000;
        fail_count++;
        test_done();
    end
endmodule
